/* gsc_pkg.sv */
// ==========================================================
// Gain loop and synthesizer control register constants
package gsc_pkg;

   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;

   // ==========================================================
   // Register indices; byte address is four times the index
   localparam logic [9:0] IDX_MODE  = 10'h35d;
   localparam logic [9:0] IDX_LOW   = 10'h35e;
   localparam logic [9:0] IDX_HIGH  = 10'h35f;
   localparam logic [9:0] IDX_GAIN  = 10'h360;
   localparam logic [9:0] IDX_AUX   = 10'h361;
   localparam logic [9:0] IDX_FERR  = 10'h372;
   localparam logic [9:0] IDX_BAND  = 10'h3cb;
   localparam logic [9:0] IDX_BIAS  = 10'h3cc;
   localparam logic [9:0] IDX_FORCE = 10'h3cd;
   localparam logic [9:0] IDX_CAL   = 10'h3d0;
   localparam logic [9:0] IDX_TRIM  = 10'h3d2;

   // ==========================================================
   // Field positions
   localparam int MODE_SEL_HI = 6;
   localparam int MODE_SEL_LO = 5;
   localparam int LNA_HI      = 4;
   localparam int LNA_LO      = 3;
   localparam int MIX_BIT     = 2;
   localparam int FLT_HI      = 1;
   localparam int FLT_LO      = 0;
   localparam int AUX_HI      = 6;
   localparam int BIAS_EN_BIT = 1;
   localparam int BAND_EN_BIT = 0;
   localparam int QREF_HI     = 5;
   localparam int QREF_LO     = 2;
   localparam int CAL_HI      = 3;
   localparam int TRIM_HI     = 5;
   localparam int TRIM_LO     = 3;

   // ==========================================================
   // Reset values and codes
   localparam logic [6:0] RST_MODE   = 7'h00;
   localparam logic [7:0] RST_LOW    = 8'h37;
   localparam logic [7:0] RST_HIGH   = 8'h69;
   localparam logic [7:0] RST_BYTE   = 8'h00;
   localparam logic [5:0] RST_FORCE  = 6'h00;
   localparam logic [3:0] RST_CAL    = 4'h1;
   localparam logic [2:0] RST_TRIM   = 3'h0;
   localparam logic [3:0] CAL_BYPASS = 4'hf;
   localparam logic [1:0] GAIN_LOW   = 2'h0;
   localparam logic [1:0] GAIN_HIGH  = 2'h2;
   localparam int FERR_UNIT_KHZ      = 1;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {LOOP_FREE, LOOP_MANUAL, LOOP_HOLD, LOOP_LOCK} gsc_loop_mode_t;
   typedef enum logic {LK_OPEN, LK_LOCKED} gsc_lock_state_t;

endpackage

/* gsc_gain_loop.sv */
`timescale 1ns/10ps
`default_nettype none
module gsc_gain_loop
   import gsc_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       arst_n,
   // Configuration
   input  wire logic [1:0] modeSel,
   input  wire logic [1:0] manualLna,
   input  wire logic       manualMix,
   input  wire logic [1:0] manualFlt,
   input  wire logic [7:0] lowLimit,
   input  wire logic [7:0] highLimit,
   // Measurement
   input  wire logic [7:0] level,
   input  wire logic       levelValid,
   input  wire logic       preambleDet,
   // Applied gains
   output logic      [1:0] appliedLna,
   output logic            appliedMix,
   output logic      [1:0] appliedFlt
);
   gsc_loop_mode_t  mode;
   gsc_lock_state_t lock_q;
   logic            canStep;

   assign mode    = gsc_loop_mode_t'(modeSel);
   // Lock mode steps only until preamble has frozen the gain
   assign canStep = levelValid && (mode == LOOP_FREE || (mode == LOOP_LOCK && lock_q == LK_OPEN));

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         lock_q <= LK_OPEN;
      end else begin
         case (lock_q)
            LK_OPEN:   if (mode == LOOP_LOCK && preambleDet) lock_q <= LK_LOCKED;
            LK_LOCKED: if (mode != LOOP_LOCK) lock_q <= LK_OPEN;
            default:   lock_q <= LK_OPEN;
         endcase
      end
   end

   // Down steps cut the front amplifier first, up steps raise the filter first
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         appliedLna <= GAIN_LOW;
         appliedMix <= 1'b0;
         appliedFlt <= GAIN_LOW;
      end else if (mode == LOOP_MANUAL) begin
         appliedLna <= manualLna;
         appliedMix <= manualMix;
         appliedFlt <= manualFlt;
      end else if (canStep && level > highLimit) begin
         if (appliedLna != GAIN_LOW) appliedLna <= appliedLna - 2'h1;
         else if (appliedMix) appliedMix <= 1'b0;
         else if (appliedFlt != GAIN_LOW) appliedFlt <= appliedFlt - 2'h1;
      end else if (canStep && level < lowLimit) begin
         if (appliedFlt < GAIN_HIGH) appliedFlt <= appliedFlt + 2'h1;
         else if (!appliedMix) appliedMix <= 1'b1;
         else if (appliedLna < GAIN_HIGH) appliedLna <= appliedLna + 2'h1;
      end
   end

   AST_MANUAL_GAIN:
   assert property (@(posedge clk) disable iff (!arst_n)
      (mode == LOOP_MANUAL) |=> ({appliedLna, appliedMix, appliedFlt} ==
                                 $past({manualLna, manualMix, manualFlt})))
      else $error("manual gains not applied");

   AST_STEP_DOWN:
   assert property (@(posedge clk) disable iff (!arst_n)
      (mode == LOOP_FREE && levelValid && level > highLimit && appliedLna != GAIN_LOW)
      |=> (appliedLna == $past(appliedLna) - 2'h1))
      else $error("gain did not step down");

   AST_HOLD:
   assert property (@(posedge clk) disable iff (!arst_n)
      (mode == LOOP_HOLD) [*2] |-> $stable({appliedLna, appliedMix, appliedFlt}))
      else $error("gain moved while held");

endmodule
`default_nettype wire

/* gsc_control_regs.sv */
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - The mode field in bits 6:5 selects free running, manual, hold or lock after preamble.
// - Applied gains read back as front amplifier 4:3, mixer 2 and filter 1:0.
// - The seven-bit auxiliary converter sample reads in bits 6:0 with bit 7 zero.
// - The carrier offset reads as an eight-bit two's complement count of 1 kHz units.
// - The forced band word replaces the calibrated band only while band forcing is on.
// - The forced bias word replaces the calibrated bias only while bias forcing is on.
// - Bit 1 of the force control register enables bias forcing and resets to zero.
// - Bit 0 of the force control register enables band forcing and resets to zero.
// - Bits 5:2 of the force control register hold the Q phase level reference, reset zero.
// - A calibration setting of 0xF skips oscillator calibration on transmit or receive entry.
// - A calibration setting of 0x1, the reset value, runs calibration on those entries.
// - Bits 5:3 of the crystal trim register hold the trim capacitor word.
module gsc_control_regs
   import gsc_pkg::*;
(
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                arst_n,
   // AXI4-Lite write
   input  wire logic [ADDR_W-1:0]   awaddr,
   input  wire logic                awvalid,
   output logic                     awready,
   input  wire logic [DATA_W-1:0]   wdata,
   input  wire logic [3:0]          wstrb,
   input  wire logic                wvalid,
   output logic                     wready,
   output logic [1:0]               bresp,
   output logic                     bvalid,
   input  wire logic                bready,
   // AXI4-Lite read
   input  wire logic [ADDR_W-1:0]   araddr,
   input  wire logic                arvalid,
   output logic                     arready,
   output logic [DATA_W-1:0]        rdata,
   output logic [1:0]               rresp,
   output logic                     rvalid,
   input  wire logic                rready,
   // Receive measurement, same clock domain
   input  wire logic [7:0]          rxLevel,
   input  wire logic                rxLevelValid,
   input  wire logic                preambleDet,
   input  wire logic [6:0]          auxSampleIn,
   input  wire logic [7:0]          freqErrorIn,
   // Synthesizer calibration, same clock domain
   input  wire logic [7:0]          calBand,
   input  wire logic [7:0]          calBias,
   input  wire logic                txRxEntry,
   // Applied controls
   output logic [1:0]               lnaGain,
   output logic                     mixerGain,
   output logic [1:0]               filterGain,
   output logic [7:0]               oscBand,
   output logic [7:0]               oscBias,
   output logic [3:0]               qPhaseRef,
   output logic                     calStart,
   output logic                     calBypassed,
   output logic [2:0]               trimCap
);
   // ==========================================================
   // Decode
   function automatic logic isMapped(input logic [ADDR_W-1:0] a);
      logic [9:0] idx;
      idx = a[ADDR_W-1:2];
      isMapped = (a[1:0] == 2'h0) &&
                 (idx == IDX_MODE || idx == IDX_LOW || idx == IDX_HIGH || idx == IDX_GAIN ||
                  idx == IDX_AUX || idx == IDX_FERR || idx == IDX_BAND || idx == IDX_BIAS ||
                  idx == IDX_FORCE || idx == IDX_CAL || idx == IDX_TRIM);
   endfunction

   logic [6:0]        mode_q;
   logic [7:0]        low_q;
   logic [7:0]        high_q;
   logic [6:0]        aux_q;
   logic [7:0]        freqErr_q;
   logic [7:0]        bandForced_q;
   logic [7:0]        biasForced_q;
   logic [5:0]        forceCtl_q;
   logic [3:0]        calWord_q;
   logic [2:0]        trim_q;
   logic              awHave_q;
   logic              wHave_q;
   logic [9:0]        wIdx_q;
   logic              wHit_q;
   logic [DATA_W-1:0] wData_q;
   logic              wLane0_q;
   logic              doWrite;
   logic              wrReg;
   logic              rdTake;
   logic [9:0]        rIdx;
   logic [7:0]        rdByte;

   // ==========================================================
   // Write channel: address and data taken in either order
   assign awready = !awHave_q && !bvalid;
   assign wready  = !wHave_q && !bvalid;
   assign doWrite = awHave_q && wHave_q && !bvalid;
   // Byte lane 0 carries every register; other lanes are ignored
   assign wrReg   = doWrite && wHit_q && wLane0_q;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         awHave_q <= 1'b0;
         wIdx_q   <= 10'h000;
         wHit_q   <= 1'b0;
      end else if (awvalid && awready) begin
         awHave_q <= 1'b1;
         wIdx_q   <= awaddr[ADDR_W-1:2];
         wHit_q   <= isMapped(awaddr);
      end else if (doWrite) begin
         awHave_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wHave_q  <= 1'b0;
         wData_q  <= '0;
         wLane0_q <= 1'b0;
      end else if (wvalid && wready) begin
         wHave_q  <= 1'b1;
         wData_q  <= wdata;
         wLane0_q <= wstrb[0];
      end else if (doWrite) begin
         wHave_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         bvalid <= 1'b0;
         bresp  <= RESP_OKAY;
      end else if (doWrite) begin
         bvalid <= 1'b1;
         bresp  <= wHit_q ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // ==========================================================
   // Writable registers; reserved bits are not stored and read zero
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mode_q       <= RST_MODE;
         low_q        <= RST_LOW;
         high_q       <= RST_HIGH;
         bandForced_q <= RST_BYTE;
         biasForced_q <= RST_BYTE;
         forceCtl_q   <= RST_FORCE;
         calWord_q    <= RST_CAL;
         trim_q       <= RST_TRIM;
      end else if (wrReg) begin
         case (wIdx_q)
            IDX_MODE:  mode_q       <= wData_q[MODE_SEL_HI:0];
            IDX_LOW:   low_q        <= wData_q[7:0];
            IDX_HIGH:  high_q       <= wData_q[7:0];
            IDX_BAND:  bandForced_q <= wData_q[7:0];
            IDX_BIAS:  biasForced_q <= wData_q[7:0];
            IDX_FORCE: forceCtl_q   <= wData_q[QREF_HI:0];
            IDX_CAL:   calWord_q    <= wData_q[CAL_HI:0];
            IDX_TRIM:  trim_q       <= wData_q[TRIM_HI:TRIM_LO];
            default:   mode_q       <= mode_q;
         endcase
      end
   end

   // ==========================================================
   // Sampled status
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         aux_q     <= 7'h00;
         freqErr_q <= 8'h00;
      end else begin
         aux_q     <= auxSampleIn;
         freqErr_q <= freqErrorIn;
      end
   end

   // ==========================================================
   // Read channel
   assign arready = !rvalid;
   assign rdTake  = arvalid && arready;
   assign rIdx    = araddr[ADDR_W-1:2];

   always_comb begin
      case (rIdx)
         IDX_MODE:  rdByte = {1'b0, mode_q};
         IDX_LOW:   rdByte = low_q;
         IDX_HIGH:  rdByte = high_q;
         IDX_GAIN:  rdByte = {3'h0, lnaGain, mixerGain, filterGain};
         IDX_AUX:   rdByte = {1'b0, aux_q};
         IDX_FERR:  rdByte = freqErr_q;
         IDX_BAND:  rdByte = bandForced_q;
         IDX_BIAS:  rdByte = biasForced_q;
         IDX_FORCE: rdByte = {2'h0, forceCtl_q};
         IDX_CAL:   rdByte = {4'h0, calWord_q};
         IDX_TRIM:  rdByte = {2'h0, trim_q, 3'h0};
         default:   rdByte = 8'h00;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rvalid <= 1'b0;
         rdata  <= '0;
         rresp  <= RESP_OKAY;
      end else if (rdTake) begin
         rvalid <= 1'b1;
         rdata  <= isMapped(araddr) ? {24'h000000, rdByte} : '0;
         rresp  <= isMapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end

   // ==========================================================
   // Synthesizer overrides and calibration sequencing
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         oscBand <= 8'h00;
         oscBias <= 8'h00;
      end else begin
         oscBand <= forceCtl_q[BAND_EN_BIT] ? bandForced_q : calBand;
         oscBias <= forceCtl_q[BIAS_EN_BIT] ? biasForced_q : calBias;
      end
   end

   assign qPhaseRef = forceCtl_q[QREF_HI:QREF_LO];
   assign trimCap   = trim_q;

   // Only 0xF bypasses; any other setting, 0x1 included, calibrates
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         calStart    <= 1'b0;
         calBypassed <= 1'b0;
      end else begin
         calStart    <= txRxEntry && (calWord_q != CAL_BYPASS);
         calBypassed <= txRxEntry && (calWord_q == CAL_BYPASS);
      end
   end

   // ==========================================================
   // Gain loop
   gsc_gain_loop i_gsc_gain_loop (
      .clk         (clk),
      .arst_n      (arst_n),
      .modeSel     (mode_q[MODE_SEL_HI:MODE_SEL_LO]),
      .manualLna   (mode_q[LNA_HI:LNA_LO]),
      .manualMix   (mode_q[MIX_BIT]),
      .manualFlt   (mode_q[FLT_HI:FLT_LO]),
      .lowLimit    (low_q),
      .highLimit   (high_q),
      .level       (rxLevel),
      .levelValid  (rxLevelValid),
      .preambleDet (preambleDet),
      .appliedLna  (lnaGain),
      .appliedMix  (mixerGain),
      .appliedFlt  (filterGain)
   );

   // ==========================================================
   // Checks
   // The edge that releases reset still loads reset values, so no attempt starts there
   AST_BAND_FORCE:
   assert property (@(posedge clk) disable iff (!arst_n)
      arst_n |=> (oscBand == ($past(forceCtl_q[BAND_EN_BIT]) ? $past(bandForced_q) : $past(calBand))))
      else $error("band override wrong");

   AST_BIAS_FORCE:
   assert property (@(posedge clk) disable iff (!arst_n)
      arst_n |=> (oscBias == ($past(forceCtl_q[BIAS_EN_BIT]) ? $past(biasForced_q) : $past(calBias))))
      else $error("bias override wrong");

   AST_CAL_SKIP:
   assert property (@(posedge clk) disable iff (!arst_n)
      (txRxEntry && calWord_q == CAL_BYPASS) |=> (calBypassed && !calStart))
      else $error("calibration not skipped");

   AST_CAL_RUN:
   assert property (@(posedge clk) disable iff (!arst_n)
      (txRxEntry && calWord_q == RST_CAL) |=> (calStart && !calBypassed))
      else $error("calibration not started");

   AST_TRIM_WRITE:
   assert property (@(posedge clk) disable iff (!arst_n)
      (wrReg && wIdx_q == IDX_TRIM) |=> (trimCap == $past(wData_q[TRIM_HI:TRIM_LO])))
      else $error("trim word not stored");

   AST_AUX_READ:
   assert property (@(posedge clk) disable iff (!arst_n)
      (rdTake && araddr == {IDX_AUX, 2'h0}) |=> (rvalid && rdata[31:7] == 25'h0 && rdata[6:0] == $past(aux_q)))
      else $error("aux sample readback wrong");

   AST_FERR_READ:
   assert property (@(posedge clk) disable iff (!arst_n)
      (rdTake && araddr == {IDX_FERR, 2'h0}) |=> (rdata[7:0] == $past(freqErr_q)))
      else $error("frequency error readback wrong");

   AST_GAIN_READ:
   assert property (@(posedge clk) disable iff (!arst_n)
      (rdTake && araddr == {IDX_GAIN, 2'h0}) |=> (rdata[4:0] == $past({lnaGain, mixerGain, filterGain})))
      else $error("gain status readback wrong");

   AST_FORCE_CTL:
   assert property (@(posedge clk) disable iff (!arst_n)
      (wrReg && wIdx_q == IDX_FORCE) |=> (forceCtl_q[1:0] == $past(wData_q[1:0])))
      else $error("force enables not stored");

endmodule
`default_nettype wire

/* gsc_control_regs_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module gsc_control_regs_bench;
   import gsc_pkg::*;

   // ==========================================================
   // Signals
   logic                clk, arst_n;
   logic [ADDR_W-1:0]   awaddr, araddr;
   logic [DATA_W-1:0]   wdata, rdata;
   logic [3:0]          wstrb, qPhaseRef;
   logic [1:0]          bresp, rresp, lnaGain, filterGain;
   logic                awvalid, awready, wvalid, wready, bvalid, bready;
   logic                arvalid, arready, rvalid, rready, mixerGain;
   logic                rxLevelValid, preambleDet, txRxEntry, calStart, calBypassed;
   logic [7:0]          rxLevel, freqErrorIn, calBand, calBias, oscBand, oscBias;
   logic [6:0]          auxSampleIn;
   logic [2:0]          trimCap;
   logic [7:0]          f;
   int                  mismatches, checks;

   // Reset table over every register, then the writable ones with their stored-bit masks
   logic [9:0]          rIdx [11] = '{IDX_MODE, IDX_LOW, IDX_HIGH, IDX_GAIN, IDX_AUX, IDX_FERR,
                                      IDX_BAND, IDX_BIAS, IDX_FORCE, IDX_CAL, IDX_TRIM};
   logic [7:0]          rVal [11] = '{8'h00, 8'h37, 8'h69, 8'h00, 8'h5a, 8'hc3,
                                      8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
   logic [9:0]          wIdx [8]  = '{IDX_MODE, IDX_LOW, IDX_HIGH, IDX_BAND, IDX_BIAS,
                                      IDX_FORCE, IDX_CAL, IDX_TRIM};
   logic [7:0]          wMsk [8]  = '{8'h7f, 8'hff, 8'hff, 8'hff, 8'hff, 8'h3f, 8'h0f, 8'h38};
   logic [7:0]          wRst [8]  = '{8'h00, 8'h37, 8'h69, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
   logic [7:0]          fTab [4]  = '{8'h00, 8'h01, 8'h02, 8'h3e};

   gsc_control_regs i_gsc_control_regs (
      .clk(clk), .arst_n(arst_n),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .rxLevel(rxLevel), .rxLevelValid(rxLevelValid), .preambleDet(preambleDet),
      .auxSampleIn(auxSampleIn), .freqErrorIn(freqErrorIn),
      .calBand(calBand), .calBias(calBias), .txRxEntry(txRxEntry),
      .lnaGain(lnaGain), .mixerGain(mixerGain), .filterGain(filterGain),
      .oscBand(oscBand), .oscBias(oscBias), .qPhaseRef(qPhaseRef),
      .calStart(calStart), .calBypassed(calBypassed), .trimCap(trimCap)
   );

   always #2 clk = ~clk;

   // ==========================================================
   // Helpers
   function automatic logic [11:0] ba(input logic [9:0] i);
      return {i, 2'b00};
   endfunction

   task automatic test_done;
      if (mismatches == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask

   task automatic tmo(input string what);
      mismatches++;
      $display("unexpected at %0t: %s timed out", $time, what);
      test_done();
   endtask

   // Handshakes are judged at the rising edge on the values standing there; the design's
   // own updates from that edge land later in the time step, so nothing races
   task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
      logic done;
      int   n;
      @(posedge clk);
      awaddr  <= a;
      wdata   <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      done = 1'b0;
      n = 0;
      while (!done) begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && bready) begin
            chk(32'(bresp), 32'(er), "bresp");
            bready <= 1'b0;
            done = 1'b1;
         end
         n++;
         if (n > 50) tmo("write");
      end
   endtask

   task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er);
      logic done;
      int   n;
      @(posedge clk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      done = 1'b0;
      n = 0;
      while (!done) begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && rready) begin
            chk(rdata, {24'h0, e}, "rdata");
            chk(32'(rresp), 32'(er), "rresp");
            rready <= 1'b0;
            done = 1'b1;
         end
         n++;
         if (n > 50) tmo("read");
      end
   endtask

   task automatic lvl(input logic [7:0] l);
      @(posedge clk);
      rxLevel      <= l;
      rxLevelValid <= 1'b1;
      @(posedge clk);
      rxLevelValid <= 1'b0;
   endtask

   task automatic entry(input logic s, input logic b);
      @(posedge clk);
      txRxEntry <= 1'b1;
      @(posedge clk);
      txRxEntry <= 1'b0;
      @(negedge clk);
      chk(32'(calStart), 32'(s), "calStart");
      chk(32'(calBypassed), 32'(b), "calBypassed");
   endtask

   // ==========================================================
   // Sequence
   initial begin
      clk = 1'b0; arst_n = 1'b0; awaddr = '0; araddr = '0; wdata = '0; wstrb = 4'h1;
      awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
      rxLevel = 8'h50; rxLevelValid = 1'b0; preambleDet = 1'b0; txRxEntry = 1'b0;
      auxSampleIn = 7'h5a; freqErrorIn = 8'hc3; calBand = 8'h11; calBias = 8'h22;
      mismatches = 0; checks = 0;
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      for (int i = 0; i < 11; i++) rd(ba(rIdx[i]), rVal[i], RESP_OKAY);
      for (int i = 0; i < 8; i++) begin
         wr(ba(wIdx[i]), 8'hff, RESP_OKAY);
         rd(ba(wIdx[i]), wMsk[i], RESP_OKAY);
         wr(ba(wIdx[i]), wRst[i], RESP_OKAY);
      end
      // Manual gains reach the ports and the status register
      wr(ba(IDX_MODE), 8'h35, RESP_OKAY);
      repeat (2) @(negedge clk);
      chk({27'h0, lnaGain, mixerGain, filterGain}, 32'h15, "manual gains");
      rd(ba(IDX_GAIN), 8'h15, RESP_OKAY);
      wr(ba(IDX_MODE), 8'h28, RESP_OKAY);
      rd(ba(IDX_GAIN), 8'h08, RESP_OKAY);
      // Hold ignores measurements
      wr(ba(IDX_MODE), 8'h48, RESP_OKAY);
      lvl(8'h80);
      lvl(8'h10);
      rd(ba(IDX_GAIN), 8'h08, RESP_OKAY);
      // Free running, including levels equal to each limit
      wr(ba(IDX_MODE), 8'h00, RESP_OKAY);
      lvl(8'h10);
      rd(ba(IDX_GAIN), 8'h09, RESP_OKAY);
      lvl(8'h80);
      rd(ba(IDX_GAIN), 8'h01, RESP_OKAY);
      lvl(8'h69);
      lvl(8'h37);
      rd(ba(IDX_GAIN), 8'h01, RESP_OKAY);
      // Lock steps until preamble, then freezes
      wr(ba(IDX_MODE), 8'h60, RESP_OKAY);
      lvl(8'h10);
      rd(ba(IDX_GAIN), 8'h02, RESP_OKAY);
      @(posedge clk);
      preambleDet <= 1'b1;
      @(posedge clk);
      preambleDet <= 1'b0;
      lvl(8'h10);
      rd(ba(IDX_GAIN), 8'h02, RESP_OKAY);
      // Oscillator forcing
      wr(ba(IDX_BAND), 8'ha5, RESP_OKAY);
      wr(ba(IDX_BIAS), 8'h5a, RESP_OKAY);
      for (int i = 0; i < 4; i++) begin
         f = fTab[i];
         wr(ba(IDX_FORCE), f, RESP_OKAY);
         repeat (2) @(negedge clk);
         chk(32'(oscBand), f[0] ? 32'ha5 : 32'h11, "oscBand");
         chk(32'(oscBias), f[1] ? 32'h5a : 32'h22, "oscBias");
         chk(32'(qPhaseRef), 32'(f[5:2]), "qPhaseRef");
      end
      // Calibration on state entry
      entry(1'b1, 1'b0);
      wr(ba(IDX_CAL), 8'h0f, RESP_OKAY);
      entry(1'b0, 1'b1);
      wr(ba(IDX_CAL), 8'h01, RESP_OKAY);
      entry(1'b1, 1'b0);
      wr(ba(IDX_TRIM), 8'h28, RESP_OKAY);
      repeat (2) @(negedge clk);
      chk(32'(trimCap), 32'h5, "trimCap");
      // Unmapped and unaligned places store nothing
      wr(ba(10'h35c), 8'hff, RESP_SLVERR);
      rd(ba(10'h35c), 8'h00, RESP_SLVERR);
      wr(12'hd75, 8'h20, RESP_SLVERR);
      rd(ba(IDX_MODE), 8'h60, RESP_OKAY);
      test_done();
   end
endmodule
`default_nettype wire
